/* hdl/sfm_config_regs.sv */
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Four-bit capability version per physical function
// - Per-function VF counts, at most six in total
// - Physical functions at numbers zero and one
// - Virtual functions only at 64 through 69
// - VFs consecutive, primary function's first
// - Offset is first VF minus own number
// - Primary offset is 64 with VFs
// - Secondary offset is 63 plus primary count
// - One 16-bit VF device ID per function
// - 32-bit page bitmap, bit n 2^(n+12)
// - Configurable dependency link per physical function

module sfm_config_regs
  import sfm_pkg::*;
#(
  parameter logic [3:0] CAP_VER_ZERO = 4'h0,
  parameter logic [3:0] CAP_VER_ONE = 4'h0,
  parameter int PF0_VFS = 1,
  parameter int PF1_VFS = 1,
  parameter logic [15:0] VF_DEVID_ZERO = 16'h0000,
  parameter logic [15:0] VF_DEVID_ONE = 16'h0000,
  parameter logic [15:0] DEP_LINK_ZERO = 16'h0000,
  parameter logic [15:0] DEP_LINK_ONE = 16'h0001,
  parameter logic [31:0] PAGE_SIZE_ZERO = 32'h0000_0001,
  parameter logic [31:0] PAGE_SIZE_ONE = 32'h0000_0001
)(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  generate
    if (PF0_VFS < 0 || PF1_VFS < 0 || PF0_VFS + PF1_VFS > MAX_VFS) begin : g_bad_count
      $error("VF counts must be non-negative and share at most six");
    end
  endgenerate

  // ----------------------------------------
  // Fixed configuration values
  // ----------------------------------------
  localparam logic [2:0] countOfPrimaryVirtuals = 3'(PF0_VFS);
  localparam logic [2:0] COUNT_ONE = 3'(PF1_VFS);
  localparam logic [2:0] COUNT_TOTAL = 3'(PF0_VFS + PF1_VFS);

  logic [7:0] physicalFunctionZero;
  logic [7:0] physicalFunctionOne;
  logic [15:0] firstVirtualOffsetZero;
  logic [15:0] firstVirtualOffsetOne;
  logic [7:0] firstVfOne;

  // Hard-wired numbers; no path from the bus reaches them
  assign physicalFunctionZero = FN_PF_ZERO;
  assign physicalFunctionOne = FN_PF_ONE;

  // Secondary function's first VF sits right after the primary's
  assign firstVfOne = FN_VF_FIRST + 8'(countOfPrimaryVirtuals);

  // Offset is a plain constant for the primary function
  assign firstVirtualOffsetZero = OFFSET_PF_ZERO;
  // Equals first VF minus own number, i.e. 63 plus count
  assign firstVirtualOffsetOne = OFFSET_PF_ONE_BASE + 16'(countOfPrimaryVirtuals);

  // ----------------------------------------
  // Lookup through the mapper
  // ----------------------------------------
  sfm_map_if mapBus();

  logic [2:0] vfSelect;

  assign mapBus.vfSel = vfSelect;
  assign mapBus.countOfPrimaryVirtuals = countOfPrimaryVirtuals;
  assign mapBus.pf1Count = COUNT_ONE;

  sfm_vf_map u_map (
    .map(mapBus.mapper)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [31:0] readValue;
  logic hit;

  // Unmapped offsets read as zero and are still answered
  always_comb begin
    readValue = 32'h0000_0000;
    hit = 1'b1;
    if (address == OFF_CAP_VERSION) begin
      readValue[3:0] = CAP_VER_ZERO;
      readValue[POS_CAP_VER_ONE +: 4] = CAP_VER_ONE;
    end else if (address == OFF_VF_COUNT) begin
      readValue[2:0] = countOfPrimaryVirtuals;
      readValue[POS_COUNT_ONE +: 3] = COUNT_ONE;
      readValue[POS_COUNT_TOTAL +: 3] = COUNT_TOTAL;
    end else if (address == OFF_FIRST_OFFSET) begin
      readValue[15:0] = firstVirtualOffsetZero;
      readValue[POS_HALF_ONE +: 16] = firstVirtualOffsetOne;
    end else if (address == OFF_VF_DEVICE_ID) begin
      readValue[15:0] = VF_DEVID_ZERO;
      readValue[POS_HALF_ONE +: 16] = VF_DEVID_ONE;
    end else if (address == OFF_DEP_LINK) begin
      readValue[15:0] = DEP_LINK_ZERO;
      readValue[POS_HALF_ONE +: 16] = DEP_LINK_ONE;
    end else if (address == OFF_PAGE_SIZE_ZERO) begin
      readValue = PAGE_SIZE_ZERO;
    end else if (address == OFF_PAGE_SIZE_ONE) begin
      readValue = PAGE_SIZE_ONE;
    end else if (address == OFF_PF_NUMBER) begin
      readValue[7:0] = physicalFunctionZero;
      readValue[POS_PF_NUM_ONE +: 8] = physicalFunctionOne;
    end else if (address == OFF_VF_SELECT) begin
      readValue[2:0] = vfSelect;
    end else if (address == OFF_VF_MAP) begin
      readValue[7:0] = mapBus.funcNum;
      readValue[POS_MAP_OWNER] = mapBus.owner;
      readValue[POS_MAP_VALID] = mapBus.valid;
    end else begin
      hit = 1'b0;
    end
  end

  // ----------------------------------------
  // Avalon slave state
  // ----------------------------------------
  logic accept;
  logic [2:0] next_vfSelect;
  logic [31:0] next_readdata;
  logic next_waitrequest;

  // One wait cycle: answer lands the edge after the request appears
  assign accept = (read || write) && waitrequest;

  always_comb begin
    next_vfSelect = vfSelect;
    next_readdata = readdata;
    next_waitrequest = 1'b1;
    if (accept) begin
      next_waitrequest = 1'b0;
      if (read) begin
        next_readdata = hit ? readValue : RST_READ_DATA;
      end
      // Only the lookup index is writable; values stay fixed
      if (write && address == OFF_VF_SELECT && byteenable[0]) begin
        next_vfSelect = writedata[2:0];
      end
    end
  end

  // Frozen while the clock enable is low
  // Limitation: enable low right after an answer stretches waitrequest low
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      vfSelect <= RST_VF_SELECT;
      readdata <= RST_READ_DATA;
      waitrequest <= 1'b1;
    end else if (clkEn) begin
      vfSelect <= next_vfSelect;
      readdata <= next_readdata;
      waitrequest <= next_waitrequest;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn || !clkEn);

  sequence s_read_at(logic [5:0] off);
    clkEn && read && waitrequest && address == off;
  endsequence

  sequence s_answer;
    !waitrequest;
  endsequence

  a_bus_answer_once: assert property (
    clkEn && (read || write) && waitrequest |=> s_answer ##1 waitrequest)
    else $error("Request not answered in one cycle");

  a_pf_numbers_fixed: assert property (
    s_read_at(OFF_PF_NUMBER) |=> s_answer
      and (readdata[15:0] == 16'h0100))
    else $error("Physical function numbers wrong");

  a_primary_offset: assert property (
    s_read_at(OFF_FIRST_OFFSET) ##0 countOfPrimaryVirtuals != 3'h0
      |=> readdata[15:0] == 16'h0040)
    else $error("Primary offset not 64");

  a_secondary_offset: assert property (
    s_read_at(OFF_FIRST_OFFSET)
      |=> readdata[31:16] == 16'(63 + PF0_VFS))
    else $error("Secondary offset not 63 plus count");

  a_offset_relation: assert property (
    firstVirtualOffsetOne == 16'(firstVfOne) - 16'(physicalFunctionOne))
    else $error("Offset differs from first VF minus PF number");

  a_vf_in_range: assert property (
    mapBus.valid |-> mapBus.funcNum >= 8'h40 && mapBus.funcNum <= 8'h45)
    else $error("Virtual function number out of range");

  a_vf_order: assert property (
    mapBus.valid |-> mapBus.owner == (vfSelect >= countOfPrimaryVirtuals)
      && mapBus.funcNum == 8'h40 + 8'(vfSelect))
    else $error("Virtual functions not packed in order");

  a_count_limit: assert property (
    s_read_at(OFF_VF_COUNT) |=> readdata[18:16] <= 3'h6
      && readdata[18:16] == readdata[2:0] + readdata[10:8])
    else $error("VF counts inconsistent or over six");

  a_write_ignored: assert property (
    clkEn && write && waitrequest && (address != OFF_VF_SELECT || !byteenable[0])
      |=> $stable(vfSelect))
    else $error("Write to fixed value changed state");

  a_version_read: assert property (
    s_read_at(OFF_CAP_VERSION)
      |=> readdata == {24'h00_0000, CAP_VER_ONE, CAP_VER_ZERO} ##1 waitrequest)
    else $error("Capability version read wrong");

  a_devid_read: assert property (
    s_read_at(OFF_VF_DEVICE_ID) |=> readdata == {VF_DEVID_ONE, VF_DEVID_ZERO})
    else $error("VF device ID read wrong");

  a_page_read: assert property (
    s_read_at(OFF_PAGE_SIZE_ONE) |=> s_answer and readdata == PAGE_SIZE_ONE)
    else $error("Page size bitmap read wrong");

  a_dep_read: assert property (
    s_read_at(OFF_DEP_LINK) |=> readdata == {DEP_LINK_ONE, DEP_LINK_ZERO})
    else $error("Dependency link read wrong");

  // ----------------------------------------
  // Handshake, read-data and index-write checks
  // ----------------------------------------
  // An answer never lasts beyond one enabled edge
  a_wait_one_cycle: assert property (
    clkEn && !waitrequest |=> waitrequest)
    else $error("Waitrequest low for more than one cycle");

  // Read data only moves on an accepted read
  a_readdata_held: assert property (
    clkEn && !(read && waitrequest) |=> $stable(readdata))
    else $error("Read data changed without a read");

  a_unmapped_zero: assert property (
    clkEn && read && waitrequest && !hit |=> s_answer and readdata == 32'h0000_0000)
    else $error("Unmapped offset did not read zero");

  // The lookup index is the only word a write may move
  a_index_write: assert property (
    clkEn && write && waitrequest && address == OFF_VF_SELECT && byteenable[0]
      |=> vfSelect == 3'($past(writedata)))
    else $error("Lookup index did not take the written value");

  // ----------------------------------------
  // Configuration field checks
  // ----------------------------------------
  a_count_fields: assert property (
    s_read_at(OFF_VF_COUNT) |=> readdata[2:0] == 3'(PF0_VFS)
      && readdata[10:8] == 3'(PF1_VFS))
    else $error("Per-function VF count read wrong");

  a_page_zero_read: assert property (
    s_read_at(OFF_PAGE_SIZE_ZERO) |=> s_answer and readdata == PAGE_SIZE_ZERO)
    else $error("Primary page size bitmap read wrong");

  // Primary offset is first VF number minus function zero
  a_primary_relation: assert property (
    firstVirtualOffsetZero == 16'(FN_VF_FIRST) - 16'(physicalFunctionZero))
    else $error("Primary offset differs from first VF minus PF number");

  // ----------------------------------------
  // Lookup checks
  // ----------------------------------------
  a_vf_primary_owner: assert property (
    mapBus.valid && vfSelect < countOfPrimaryVirtuals |-> !mapBus.owner)
    else $error("Primary virtual function given to secondary");

  // Secondary's first slot lands right after the primary's last
  a_vf_secondary_start: assert property (
    mapBus.valid && vfSelect == countOfPrimaryVirtuals
      |-> mapBus.owner && mapBus.funcNum == firstVfOne)
    else $error("Secondary virtual functions do not follow primary");

  // Indices past the six slots must never name a function
  a_vf_beyond_slots: assert property (
    int'(vfSelect) >= MAX_VFS |-> !mapBus.valid && mapBus.funcNum == 8'h00)
    else $error("Index beyond six slots mapped a function");

endmodule // sfm_config_regs
`default_nettype wire

/* hdl/sfm_map_if.sv */
`timescale 1ns/100ps
`default_nettype none

// Index-to-function lookup between register bank and mapper
interface sfm_map_if;
  logic [2:0] vfSel;
  logic [2:0] countOfPrimaryVirtuals;
  logic [2:0] pf1Count;
  logic [7:0] funcNum;
  logic owner;
  logic valid;

  modport requester(
    output vfSel,
    output countOfPrimaryVirtuals,
    output pf1Count,
    input funcNum,
    input owner,
    input valid
  );

  modport mapper(
    input vfSel,
    input countOfPrimaryVirtuals,
    input pf1Count,
    output funcNum,
    output owner,
    output valid
  );
endinterface
`default_nettype wire

/* hdl/sfm_pkg.sv */
package sfm_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [5:0] OFF_CAP_VERSION = 6'h00;
  localparam logic [5:0] OFF_VF_COUNT = 6'h04;
  localparam logic [5:0] OFF_FIRST_OFFSET = 6'h08;
  localparam logic [5:0] OFF_VF_DEVICE_ID = 6'h0C;
  localparam logic [5:0] OFF_DEP_LINK = 6'h10;
  localparam logic [5:0] OFF_PAGE_SIZE_ZERO = 6'h14;
  localparam logic [5:0] OFF_PAGE_SIZE_ONE = 6'h18;
  localparam logic [5:0] OFF_PF_NUMBER = 6'h1C;
  localparam logic [5:0] OFF_VF_SELECT = 6'h20;
  localparam logic [5:0] OFF_VF_MAP = 6'h24;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int POS_CAP_VER_ONE = 4;
  localparam int POS_COUNT_ONE = 8;
  localparam int POS_COUNT_TOTAL = 16;
  localparam int POS_HALF_ONE = 16;
  localparam int POS_PF_NUM_ONE = 8;
  localparam int POS_MAP_OWNER = 8;
  localparam int POS_MAP_VALID = 9;

  // ----------------------------------------
  // Fixed function map
  // ----------------------------------------
  localparam logic [7:0] FN_PF_ZERO = 8'h00;
  localparam logic [7:0] FN_PF_ONE = 8'h01;
  localparam logic [7:0] FN_VF_FIRST = 8'h40;
  localparam logic [7:0] FN_VF_LAST = 8'h45;
  localparam logic [15:0] OFFSET_PF_ZERO = 16'h0040;
  localparam logic [15:0] OFFSET_PF_ONE_BASE = 16'h003F;
  localparam int MAX_VFS = 6;
  localparam int PAGE_SHIFT_BASE = 12;

  // ----------------------------------------
  // Reset values and bus timing
  // ----------------------------------------
  localparam logic [2:0] RST_VF_SELECT = 3'h0;
  localparam logic [31:0] RST_READ_DATA = 32'h0000_0000;
  localparam int ANSWER_CYCLES = 1;

  typedef logic [2:0] sfm_vfidx_t;

endpackage

/* hdl/sfm_vf_map.sv */
`timescale 1ns/100ps
`default_nettype none

module sfm_vf_map
  import sfm_pkg::*;
(
  sfm_map_if.mapper map
);

  // ----------------------------------------
  // Per-slot table
  // ----------------------------------------
  logic [7:0] slotFunc [MAX_VFS];
  logic [MAX_VFS-1:0] slotOwner;
  logic [MAX_VFS-1:0] slotUsed;
  logic [3:0] totalCount;

  assign totalCount = {1'b0, map.countOfPrimaryVirtuals} + {1'b0, map.pf1Count};

  // Slots packed upward, primary virtuals first
  genvar gi;
  generate
    for (gi = 0; gi < MAX_VFS; gi++) begin : g_slot
      assign slotFunc[gi] = FN_VF_FIRST + 8'(gi);
      assign slotOwner[gi] = (4'(gi) >= {1'b0, map.countOfPrimaryVirtuals});
      assign slotUsed[gi] = (4'(gi) < totalCount);
    end
  endgenerate

  // Select; out-of-range index reports invalid
  always_comb begin
    map.funcNum = 8'h00;
    map.owner = 1'b0;
    map.valid = 1'b0;
    if (int'(map.vfSel) < MAX_VFS) begin
      map.funcNum = slotFunc[map.vfSel];
      map.owner = slotOwner[map.vfSel];
      map.valid = slotUsed[map.vfSel];
    end
  end

endmodule // sfm_vf_map
`default_nettype wire

/* sim/sfm_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Configuration software seen as a bus master
// ----------------------------------------
module sfm_host_model (
  input wire logic core_clk,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output logic [5:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable
);
  // Idle bus at time zero
  initial begin
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'h0;
  end

  // One word transfer; waits as long as the slave stalls
  task automatic doAccess(input logic wr, input logic [5:0] addr, input logic [31:0] data,
                          input logic [3:0] be, output logic [31:0] rd);
    @(posedge core_clk);
    address <= addr;
    read <= !wr;
    write <= wr;
    writedata <= data;
    byteenable <= be;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // Released lines show junk so stale values cannot pass
    address <= ~addr;
    writedata <= ~data;
  endtask
endmodule // sfm_host_model
`default_nettype wire

/* sim/tb_sfm_config_regs.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_sfm_config_regs;
  import sfm_pkg::*;
  localparam logic [3:0] CV0 = 4'h5;
  localparam logic [3:0] CV1 = 4'hA;
  localparam int V0 = 2;
  localparam int V1 = 4;
  localparam logic [15:0] DEV0 = 16'h1234;
  localparam logic [15:0] DEV1 = 16'h5678;
  localparam logic [15:0] DEP0 = 16'h0002;
  localparam logic [15:0] DEP1 = 16'h0003;
  localparam logic [31:0] PG0 = 32'h0000_0013;
  localparam logic [31:0] PG1 = 32'h8000_0001;

  logic core_clk, resetn, clkEn, read, write, waitrequest;
  logic [5:0] address;
  logic [31:0] writedata, readdata, lfsr, rd;
  logic [3:0] byteenable;
  logic [2:0] idx;
  logic [31:0] expQ[$];
  int fail_count, samples_checked, cycles;

  sfm_config_regs #(.CAP_VER_ZERO(CV0), .CAP_VER_ONE(CV1), .PF0_VFS(V0), .PF1_VFS(V1),
    .VF_DEVID_ZERO(DEV0), .VF_DEVID_ONE(DEV1), .DEP_LINK_ZERO(DEP0), .DEP_LINK_ONE(DEP1),
    .PAGE_SIZE_ZERO(PG0), .PAGE_SIZE_ONE(PG1)) dut (.core_clk(core_clk), .resetn(resetn),
    .clkEn(clkEn), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest));

  sfm_host_model host (.core_clk(core_clk), .waitrequest(waitrequest), .readdata(readdata),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable));

  // ----------------------------------------
  // Clock, helpers, report
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsrStep(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected word per offset, from the configured values
  function automatic logic [31:0] expVal(input logic [5:0] a, input logic [2:0] i);
    case (a)
      6'h00: return {24'h0, CV1, CV0};
      6'h04: return {13'h0, 3'(V0 + V1), 5'h0, 3'(V1), 5'h0, 3'(V0)};
      6'h08: return {16'(63 + V0), 16'd64};
      6'h0C: return {DEV1, DEV0};
      6'h10: return {DEP1, DEP0};
      6'h14: return PG0;
      6'h18: return PG1;
      6'h1C: return 32'h0000_0100;
      6'h20: return {29'h0, i};
      6'h24: return (i < 3'd6) ? {22'h0, 1'b1, (i >= 3'(V0)), 8'd64 + 8'(i)} : 32'h0;
      default: return 32'h0000_0000;
    endcase
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Read with the expected word noted first, then a random idle gap
  task automatic rdExp(input logic [5:0] a);
    expQ.push_back(expVal(a, idx));
    host.doAccess(1'b0, a, 32'h0, 4'hF, rd);
    lfsr = lfsrStep(lfsr);
    repeat (lfsr[1:0]) @(posedge core_clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
    host.doAccess(1'b1, a, d, be, rd);
  endtask

  task automatic doReset();
    resetn <= 1'b0;
    repeat (6) @(posedge core_clk);
    check("waitrequest", {31'h0, waitrequest}, 32'h1);
    check("readdata", readdata, RST_READ_DATA);
    resetn <= 1'b1;
    idx = RST_VF_SELECT;
  endtask

  // ----------------------------------------
  // Result watcher and timeout
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (resetn === 1'b1 && read === 1'b1 && waitrequest === 1'b0) begin
      if (expQ.size() > 0)
        check("readdata", readdata, expQ.pop_front());
      else
        check("unexpected answer", 32'h1, 32'h0);
    end
  end

  // Random clock-enable gaps stretch the answer; cycle count keeps gaps short
  // Enable up after an answer: a frozen low waitrequest reads as a second one
  always @(posedge core_clk) begin
    clkEn <= ((lfsr[5:4] ^ 2'(cycles)) != 2'b00) || !waitrequest;
    cycles <= cycles + 1;
    if (cycles >= 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    clkEn = 1'b1;
    lfsr = 32'hc12d;
    cycles = 0;
    fail_count = 0;
    samples_checked = 0;
    idx = 3'h0;
    doReset();
    // Whole map incl. unmapped words; RO words survive random writes
    for (int a = 0; a < 64; a += 4) begin
      rdExp(6'(a));
      if (a != 32) begin
        lfsr = lfsrStep(lfsr);
        wr(6'(a), lfsr, 4'hF);
        rdExp(6'(a));
      end
    end
    // Every slot and the two beyond: map, owner, range
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsrStep(lfsr);
      wr(OFF_VF_SELECT, {lfsr[31:3], 3'(i)}, 4'hF);
      idx = 3'(i);
      rdExp(OFF_VF_SELECT);
      rdExp(OFF_VF_MAP);
    end
    // Lane 0 off: index must not move
    wr(OFF_VF_SELECT, 32'h0000_0003, 4'hE);
    rdExp(OFF_VF_SELECT);
    rdExp(OFF_FIRST_OFFSET);
    rdExp(OFF_PF_NUMBER);
    // Reset in mid-run returns the index to zero
    doReset();
    rdExp(OFF_VF_SELECT);
    rdExp(OFF_VF_MAP);
    repeat (4) @(posedge core_clk);
    check("queue empty", 32'(expQ.size()), 32'h0);
    end_of_test();
  end
endmodule // tb_sfm_config_regs
`default_nettype wire
